//--- bms_boot_mode_consts.vh
// Constants shared by the boot-mode select logic
`ifndef BMS_BOOT_MODE_CONSTS_VH
`define BMS_BOOT_MODE_CONSTS_VH

// ----------------------------------------------------------------
// Boot mode encodings
// ----------------------------------------------------------------
`define BMS_MODE_W 3
`define BMS_MODE_NONE 3'h0
`define BMS_MODE_EPROM 3'h1
`define BMS_MODE_HOST 3'h2
`define BMS_MODE_LINK 3'h3
`define BMS_MODE_RESERVED 3'h7

// ----------------------------------------------------------------
// Strap vector layout {rom, link, bms}
// ----------------------------------------------------------------
`define BMS_STRAP_W 3
`define BMS_STRAP_ROM 2
`define BMS_STRAP_LINK 1
`define BMS_STRAP_BMS 0
`define BMS_STRAP_RST 3'h0
`define BMS_STRAPS_EPROM_LO 3'h4
`define BMS_STRAPS_EPROM_HI 3'h5
`define BMS_STRAPS_HOST 3'h1
`define BMS_STRAPS_LINK 3'h3
`define BMS_STRAPS_NONE 3'h0

// ----------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------
`define BMS_SETTLE_W 4
`define BMS_SETTLE_CYCLES 4'h3
`define BMS_SETTLE_ZERO 4'h0
`define BMS_SETTLE_ONE 4'h1
`define BMS_EPROM_WIDTH 8'h08
`define BMS_EPROM_WIDTH_NONE 8'h00
`define BMS_RESET_VECTOR_DFLT 32'h00000000
`define BMS_ADDR_W 32
`define BMS_INSTR_CNT_W 32
`define BMS_INSTR_CNT_ZERO 32'h00000000
`define BMS_INSTR_CNT_ONE 32'h00000001

`endif

//--- bms_sync.v
// Two-flop synchroniser for asynchronous strap pins
module bms_sync #(
   parameter WIDTH = 3
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Asynchronous input and synchronised output
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_r;
   reg [WIDTH-1:0] stage2_r;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   // First stage feeds only the second stage to keep metastability contained
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stage1_r <= {WIDTH{1'b0}};
         stage2_r <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;

endmodule

//--- bms_boot_mode_select.v
// Boot-mode strap decode, boot-memory-select pin control and reset entry
`include "bms_boot_mode_consts.vh"

module bms_boot_mode_select #(
   parameter [`BMS_ADDR_W-1:0] RESET_VECTOR = `BMS_RESET_VECTOR_DFLT,
   parameter [`BMS_SETTLE_W-1:0] SETTLE_CYCLES = `BMS_SETTLE_CYCLES
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Boot strap pins
   input wire romBootSel,
   input wire linkBootSel,
   // Boot memory select pin, split into its three signals
   input wire bootMemorySelectIn,
   output wire bootMemorySelectOut,
   output wire bootMemorySelectOen,
   // Shared-bus ownership and EPROM access request from the bus logic
   input wire busMaster,
   input wire romCsReq,
   // Decoded boot configuration
   output wire [`BMS_MODE_W-1:0] bootMode,
   output wire modeValid,
   output wire bootLoad,
   output wire execDirect,
   output wire [7:0] epromWidth,
   // Strap health
   output wire strapReserved,
   output wire strapChanged,
   // Execution start
   output wire fetchStart,
   output wire [`BMS_ADDR_W-1:0] fetchAddr,
   output wire instrCycle,
   output wire [`BMS_INSTR_CNT_W-1:0] instrCount
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam ST_SETTLE = 3'b001;
   localparam ST_LATCH = 3'b010;
   localparam ST_RUN = 3'b100;
   localparam [`BMS_SETTLE_W-1:0] SETTLE_LAST = SETTLE_CYCLES;

   // ----------------------------------------------------------------
   // Strap decode
   // ----------------------------------------------------------------
   function [`BMS_MODE_W-1:0] decodeMode;
      input [`BMS_STRAP_W-1:0] s;
      begin
         case (s)
            `BMS_STRAPS_EPROM_LO, `BMS_STRAPS_EPROM_HI:
               decodeMode = `BMS_MODE_EPROM;
            `BMS_STRAPS_HOST: decodeMode = `BMS_MODE_HOST;
            `BMS_STRAPS_LINK: decodeMode = `BMS_MODE_LINK;
            `BMS_STRAPS_NONE: decodeMode = `BMS_MODE_NONE;
            default: decodeMode = `BMS_MODE_RESERVED;
         endcase
      end
   endfunction

   function isBootMode;
      input [`BMS_MODE_W-1:0] m;
      begin
         isBootMode = (m == `BMS_MODE_EPROM) || (m == `BMS_MODE_HOST) ||
            (m == `BMS_MODE_LINK);
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [`BMS_STRAP_W-1:0] strapSync;
   wire [`BMS_MODE_W-1:0] liveMode;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`BMS_SETTLE_W-1:0] settle_r;
   reg [`BMS_STRAP_W-1:0] strapLatch_r;
   reg [`BMS_MODE_W-1:0] mode_r;
   reg modeValid_r;
   reg bootLoad_r;
   reg execDirect_r;
   reg [7:0] epromWidth_r;
   reg strapReserved_r;
   reg strapChanged_r;
   reg fetchStart_r;
   reg [`BMS_ADDR_W-1:0] fetchAddr_r;
   reg instrCycle_r;
   reg [`BMS_INSTR_CNT_W-1:0] instrCount_r;
   reg bmsOut_r;
   reg bmsOen_r;
   reg bmsDrive;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   bms_sync #(
      .WIDTH(`BMS_STRAP_W)
   ) u_strapSync (
      .clock(clock),
      .rst(rst),
      .asyncIn({romBootSel, linkBootSel, bootMemorySelectIn}),
      .syncOut(strapSync)
   );

   assign liveMode = decodeMode(strapSync);

   // ----------------------------------------------------------------
   // Reset-entry sequencer
   // ----------------------------------------------------------------
   // Waiting a few cycles lets the synchroniser fill with real pin levels
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_SETTLE:
         begin
            if (settle_r == SETTLE_LAST)
               state_nxt = ST_LATCH;
         end
         ST_LATCH:
            state_nxt = ST_RUN;
         ST_RUN:
            state_nxt = ST_RUN;
         default:
            state_nxt = ST_SETTLE;
      endcase
   end

   // Every register takes a constant under reset
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_SETTLE;
         settle_r <= `BMS_SETTLE_ZERO;
         strapLatch_r <= `BMS_STRAP_RST;
         mode_r <= `BMS_MODE_NONE;
         modeValid_r <= 1'b0;
         bootLoad_r <= 1'b0;
         execDirect_r <= 1'b0;
         epromWidth_r <= `BMS_EPROM_WIDTH_NONE;
         strapReserved_r <= 1'b0;
         fetchStart_r <= 1'b0;
         fetchAddr_r <= `BMS_RESET_VECTOR_DFLT;
      end
      else
      begin
         state_r <= state_nxt;
         fetchStart_r <= 1'b0;
         if (state_r == ST_SETTLE)
            settle_r <= settle_r + `BMS_SETTLE_ONE;
         if (state_r == ST_LATCH)
         begin
            // Straps caught once after release and then frozen
            strapLatch_r <= strapSync;
            mode_r <= liveMode;
            modeValid_r <= (liveMode != `BMS_MODE_RESERVED);
            strapReserved_r <= (liveMode == `BMS_MODE_RESERVED);
            bootLoad_r <= isBootMode(liveMode);
            execDirect_r <= (liveMode == `BMS_MODE_NONE);
            epromWidth_r <= (liveMode == `BMS_MODE_EPROM) ?
               `BMS_EPROM_WIDTH : `BMS_EPROM_WIDTH_NONE;
            fetchStart_r <= 1'b1;
            fetchAddr_r <= RESET_VECTOR;
         end
      end
   end

   // ----------------------------------------------------------------
   // Instruction cycle timing
   // ----------------------------------------------------------------
   // No divider: the core advances once per input clock edge
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         instrCycle_r <= 1'b0;
         instrCount_r <= `BMS_INSTR_CNT_ZERO;
      end
      else if (state_r == ST_RUN)
      begin
         instrCycle_r <= 1'b1;
         instrCount_r <= instrCount_r + `BMS_INSTR_CNT_ONE;
      end
   end

   // ----------------------------------------------------------------
   // Strap change monitor
   // ----------------------------------------------------------------
   // Memory select is ignored in EPROM mode since the pin is then our output
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         strapChanged_r <= 1'b0;
      else if (state_r == ST_RUN)
      begin
         if ((strapSync[`BMS_STRAP_ROM] != strapLatch_r[`BMS_STRAP_ROM]) ||
            (strapSync[`BMS_STRAP_LINK] != strapLatch_r[`BMS_STRAP_LINK]) ||
            ((mode_r != `BMS_MODE_EPROM) &&
            (strapSync[`BMS_STRAP_BMS] != strapLatch_r[`BMS_STRAP_BMS])))
            strapChanged_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Boot memory select pin control
   // ----------------------------------------------------------------
   // Pin stays an input until the mode is known, so it can be sampled
   always @*
   begin
      bmsDrive = (state_r == ST_RUN) && (mode_r == `BMS_MODE_EPROM);
      bmsDrive = bmsDrive && busMaster;
   end

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         bmsOut_r <= 1'b1;
         bmsOen_r <= 1'b1;
      end
      else
      begin
         bmsOen_r <= ~bmsDrive;
         bmsOut_r <= bmsDrive ? ~romCsReq : 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bootMemorySelectOut = bmsOut_r;
   assign bootMemorySelectOen = bmsOen_r;
   assign bootMode = mode_r;
   assign modeValid = modeValid_r;
   assign bootLoad = bootLoad_r;
   assign execDirect = execDirect_r;
   assign epromWidth = epromWidth_r;
   assign strapReserved = strapReserved_r;
   assign strapChanged = strapChanged_r;
   assign fetchStart = fetchStart_r;
   assign fetchAddr = fetchAddr_r;
   assign instrCycle = instrCycle_r;
   assign instrCount = instrCount_r;

endmodule

//--- bms_boot_mode_select_sva.sv
// Assertion checker for the boot-mode select block
`include "bms_boot_mode_consts.vh"
module bms_boot_mode_select_sva #(
   parameter RESET_VECTOR = `BMS_RESET_VECTOR_DFLT
) (
   // Clock and reset
   input wire clock,
   input wire rst,
   // Pins and bus control
   input wire romBootSel,
   input wire linkBootSel,
   input wire bootMemorySelectIn,
   input wire bootMemorySelectOut,
   input wire bootMemorySelectOen,
   input wire busMaster,
   input wire romCsReq,
   // Decode and execution
   input wire [`BMS_MODE_W-1:0] bootMode,
   input wire bootLoad,
   input wire execDirect,
   input wire [7:0] epromWidth,
   input wire fetchStart,
   input wire [`BMS_ADDR_W-1:0] fetchAddr,
   input wire instrCycle,
   input wire [`BMS_INSTR_CNT_W-1:0] instrCount
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Straps are stable while the latch happens, so the live pins still match
   function automatic [2:0] expMode(input r, input l, input b);
      expMode = r ? (l ? `BMS_MODE_RESERVED : `BMS_MODE_EPROM) : (l ?
         (b ? `BMS_MODE_LINK : `BMS_MODE_RESERVED) : (b ? `BMS_MODE_HOST : `BMS_MODE_NONE));
   endfunction
   a_mode_decode: assert property (
      $rose(fetchStart) |-> bootMode == expMode(romBootSel, linkBootSel, bootMemorySelectIn))
      else $error("decoded mode differs from straps");
   a_eprom_width: assert property (
      bootMode == `BMS_MODE_EPROM |-> epromWidth == 8'h08 && bootLoad)
      else $error("EPROM mode without 8-bit width");
   a_pin_float: assert property (
      bootMode != `BMS_MODE_EPROM |-> bootMemorySelectOen)
      else $error("pin driven outside EPROM mode");
   a_bus_owner: assert property (!busMaster |=> bootMemorySelectOen)
      else $error("pin driven while not bus owner");
   a_cs_drive: assert property (
      instrCycle && bootMode == `BMS_MODE_EPROM && busMaster && romCsReq
      |=> !bootMemorySelectOen && !bootMemorySelectOut)
      else $error("EPROM chip select not driven");
   a_no_boot: assert property (
      execDirect |-> bootMode == `BMS_MODE_NONE && !bootLoad)
      else $error("direct execution with boot load");
   a_one_instr: assert property (
      instrCycle && $past(instrCycle) |-> instrCount == $past(instrCount) + 1)
      else $error("instruction count not one per clock");
   a_fetch_vector: assert property (
      fetchStart |-> fetchAddr == RESET_VECTOR ##1 (!fetchStart && instrCycle))
      else $error("fetch start wrong vector or length");
   a_mode_held: assert property (
      instrCycle |-> $stable(bootMode) && $stable(epromWidth))
      else $error("boot mode changed while running");
endmodule
bind bms_boot_mode_select bms_boot_mode_select_sva #(.RESET_VECTOR(RESET_VECTOR)) chk_u (.*);

//--- bms_board_model.sv
// Board strap wiring and boot EPROM chip select seen by the device
module bms_board_model (
   // Strap level of the boot memory select net
   input wire strapLevel,
   // Device side of the pin
   input wire pinOut,
   input wire pinOen,
   // Resolved net and EPROM select
   output wire pinLevel,
   output wire romSelected
);
   timeunit 1ns;
   timeprecision 100ps;
   // Strap resistor owns the net whenever the device lets go of it
   assign pinLevel = pinOen ? strapLevel : pinOut;
   assign romSelected = !pinLevel;
endmodule

//--- tb_boot_mode_select.sv
// Self-checking testbench for the boot-mode select block
`include "bms_boot_mode_consts.vh"
module tb_boot_mode_select;
   timeunit 1ns;
   timeprecision 100ps;
   localparam [31:0] VECTOR = 32'h00000100;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic romBootSel = 1'b0;
   logic linkBootSel = 1'b0;
   logic strapLevel = 1'b1;
   logic busMaster = 1'b0;
   logic romCsReq = 1'b0;
   wire pinLevel, bmsOut, bmsOen, romSelected, modeValid, bootLoad, execDirect;
   wire strapReserved, strapChanged, fetchStart, instrCycle;
   wire [2:0] bootMode;
   wire [7:0] epromWidth;
   wire [31:0] fetchAddr, instrCount;
   integer num_errors = 0;
   integer compares = 0;
   integer cycles = 0;
   initial forever #2.5 clock = ~clock;
   bms_boot_mode_select #(.RESET_VECTOR(VECTOR), .SETTLE_CYCLES(`BMS_SETTLE_CYCLES)) dut_u (
      .clock(clock), .rst(rst), .romBootSel(romBootSel), .linkBootSel(linkBootSel),
      .bootMemorySelectIn(pinLevel), .bootMemorySelectOut(bmsOut),
      .bootMemorySelectOen(bmsOen), .busMaster(busMaster), .romCsReq(romCsReq),
      .bootMode(bootMode), .modeValid(modeValid), .bootLoad(bootLoad),
      .execDirect(execDirect), .epromWidth(epromWidth), .strapReserved(strapReserved),
      .strapChanged(strapChanged), .fetchStart(fetchStart), .fetchAddr(fetchAddr),
      .instrCycle(instrCycle), .instrCount(instrCount));
   bms_board_model board_u (.strapLevel(strapLevel), .pinOut(bmsOut), .pinOen(bmsOen),
      .pinLevel(pinLevel), .romSelected(romSelected));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task check(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
         end
      end
   endtask
   // Straps are set inside reset, as a hardwired board would present them
   task do_reset(input r, input l, input b);
      begin
         @(posedge clock);
         rst <= 1'b1;
         romBootSel <= r;
         linkBootSel <= l;
         strapLevel <= b;
         busMaster <= 1'b0;
         romCsReq <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
         check(bootMode, `BMS_MODE_NONE);
         check(instrCount, 32'h0);
         @(posedge clock);
         rst <= 1'b0;
         repeat (7) @(posedge clock);
         #1;
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task test_decode_all;
      reg [2:0] s, m;
      begin
         for (int i = 0; i < 8; i++)
         begin
            s = i[2:0];
            m = s[2] ? (s[1] ? `BMS_MODE_RESERVED : `BMS_MODE_EPROM) : (s[1] ? (s[0] ?
               `BMS_MODE_LINK : `BMS_MODE_RESERVED) : (s[0] ? `BMS_MODE_HOST : `BMS_MODE_NONE));
            do_reset(s[2], s[1], s[0]);
            @(posedge clock);
            busMaster <= 1'b1;
            romCsReq <= 1'b1;
            @(posedge clock);
            #1;
            check(bootMode, m);
            check(epromWidth, (m == `BMS_MODE_EPROM) ? 32'h8 : 32'h0);
            check(modeValid, m != `BMS_MODE_RESERVED);
            check(execDirect, m == `BMS_MODE_NONE);
            check(bootLoad, m != `BMS_MODE_NONE && m != `BMS_MODE_RESERVED);
            check(strapReserved, m == `BMS_MODE_RESERVED);
            check(bmsOen, m != `BMS_MODE_EPROM);
         end
      end
   endtask
   task test_pin_drive;
      begin
         do_reset(1'b1, 1'b0, 1'b1);
         @(posedge clock);
         busMaster <= 1'b1;
         romCsReq <= 1'b1;
         @(posedge clock);
         #1;
         check(romSelected, 1'b1);
         @(posedge clock);
         romCsReq <= 1'b0;
         @(posedge clock);
         #1;
         check({bmsOen, pinLevel}, 2'b01);
         @(posedge clock);
         busMaster <= 1'b0;
         @(posedge clock);
         #1;
         check(bmsOen, 1'b1);
      end
   endtask
   task test_latch_hold;
      begin
         do_reset(1'b0, 1'b1, 1'b1);
         @(posedge clock);
         // Moves to the legal no-boot straps, never a reserved combination
         linkBootSel <= 1'b0;
         strapLevel <= 1'b0;
         repeat (6) @(posedge clock);
         #1;
         check(bootMode, `BMS_MODE_LINK);
         check(strapChanged, 1'b1);
      end
   endtask
   task test_fetch;
      reg [31:0] c;
      begin
         do_reset(1'b0, 1'b0, 1'b1);
         for (int n = 0; n < 8 && fetchStart !== 1'b1; n++)
         begin
            @(posedge clock);
            #1;
         end
         check(fetchStart, 1'b0);
         @(posedge clock);
         rst <= 1'b1;
         @(posedge clock);
         rst <= 1'b0;
         for (int n = 0; n < 20 && fetchStart !== 1'b1; n++)
         begin
            @(posedge clock);
            #1;
         end
         check(fetchStart, 1'b1);
         check(fetchAddr, VECTOR);
         @(posedge clock);
         #1;
         check(instrCycle, 1'b1);
         c = instrCount;
         repeat (10) @(posedge clock);
         #1;
         check(instrCount, c + 10);
      end
   endtask
   task report_and_stop;
      begin
         $display("Compares %0d, errors %0d", compares, num_errors);
         if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Run is under two hundred cycles; the ceiling leaves ample margin
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end
   initial
   begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      test_decode_all;
      test_pin_drive;
      test_latch_hold;
      test_fetch;
      report_and_stop;
   end
endmodule
